// File: rtl/dpc_capture_top.sv
/*
  Dual position capture: two independent units latching the motor position
  on a chosen edge of their trigger inputs, with a fieldbus parameter port.
  Assumes motor_pos_i, ref_update_i, ref_delta_i and fieldbus_ctrl_i come
  from logic on ref_clk_i; the trigger pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none

module dpc_capture_top
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Trigger pins
  input wire logic positive_limit_or_trigger_a_pin_i,
  input wire logic negative_limit_or_trigger_b_pin_i,
  // Drive state
  input wire logic [31:0] motor_pos_i,
  input wire logic ref_update_i,
  input wire logic [31:0] ref_delta_i,
  input wire logic fieldbus_ctrl_i,
  // Fieldbus parameter port
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [31:0] param_wdata_i,
  output logic [31:0] param_rdata_o,
  output logic param_rvalid_o,
  output logic param_err_o,
  // Status
  output logic [1:0] capture_done_flags_o
);

  // One-hot unit select for a pair of per-unit addresses
  function automatic logic [1:0] unit_sel(
    input logic [15:0] addr,
    input logic [15:0] addr_a,
    input logic [15:0] addr_b
  );
    unit_sel = {addr == addr_b, addr == addr_a};
  endfunction

  // Run control readback value of a mode
  function automatic logic [15:0] mode_code(input dpc_mode_t mode);
    case (mode)
      DPC_SINGLE: mode_code = DPC_RUN_SINGLE;
      DPC_CONT: mode_code = DPC_RUN_CONT;
      default: mode_code = DPC_RUN_ABORT;
    endcase
  endfunction

  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] trig_pin;

  assign trig_pin = {negative_limit_or_trigger_b_pin_i, positive_limit_or_trigger_a_pin_i};

  dpc_edge_sync u_sync_a (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_i(trig_pin[0]),
    .rise_o(rise[0]),
    .fall_o(fall[0])
  );

  dpc_edge_sync u_sync_b (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_i(trig_pin[1]),
    .rise_o(rise[1]),
    .fall_o(fall[1])
  );

  // Per-unit state, indexed 0 for unit A and 1 for unit B
  dpc_mode_t mode_q [2];
  dpc_mode_t mode_d [2];
  logic [1:0] edge_q;
  logic [1:0] edge_d;
  logic [31:0] pos_q [2];
  logic [31:0] pos_d [2];
  logic [15:0] cnt_q [2];
  logic [15:0] cnt_d [2];
  logic [1:0] done_q;
  logic [1:0] done_d;

  // Parameter port answer
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic err_q;
  logic err_d;

  logic [1:0] run_wsel;
  logic [1:0] edge_wsel;

  assign run_wsel = param_wr_i ? unit_sel(param_addr_i, DPC_ADDR_A_RUN, DPC_ADDR_B_RUN) : 2'h0;
  assign edge_wsel = param_wr_i ? unit_sel(param_addr_i, DPC_ADDR_A_EDGE, DPC_ADDR_B_EDGE) : 2'h0;

  // Run and edge values only act with the upper half clear, matching the refusal reported
  logic hi_clear;
  assign hi_clear = (param_wdata_i[31:16] == 16'h0000);

  // Unit behaviour
  always_comb
  begin
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      mode_d[i] = mode_q[i];
      pos_d[i] = pos_q[i];
      cnt_d[i] = cnt_q[i];
    end
    edge_d = edge_q;
    done_d = done_q;

    for (int i = 0; i < 2; i++)
    begin
      // Arming and abort; arming outside fieldbus control is ignored
      if (run_wsel[i] && hi_clear)
      begin
        case (param_wdata_i[15:0])
          DPC_RUN_ABORT:
          begin
            mode_d[i] = DPC_IDLE;
          end
          DPC_RUN_SINGLE:
          begin
            if (fieldbus_ctrl_i)
            begin
              mode_d[i] = DPC_SINGLE;
              cnt_d[i] = DPC_CNT_RST;
              done_d[i] = DPC_DONE_RST;
            end
          end
          DPC_RUN_CONT:
          begin
            if (fieldbus_ctrl_i)
            begin
              mode_d[i] = DPC_CONT;
              cnt_d[i] = DPC_CNT_RST;
              done_d[i] = DPC_DONE_RST;
            end
          end
          default:
          begin
            mode_d[i] = mode_q[i];
          end
        endcase
      end

      if (edge_wsel[i] && hi_clear && (param_wdata_i[15:0] <= DPC_EDGE_RISE))
      begin
        edge_d[i] = param_wdata_i[0];
      end

      // Keep stored value consistent with a redefined position reference
      if (ref_update_i)
      begin
        pos_d[i] = pos_q[i] + ref_delta_i;
      end

      // A capture in the arming cycle is judged under the new mode, so it is kept
      hit = (edge_q[i] == DPC_EDGE_RISE[0]) ? rise[i] : fall[i];
      if (hit)
      begin
        case (mode_d[i])
          DPC_SINGLE:
          begin
            pos_d[i] = motor_pos_i;
            cnt_d[i] = cnt_d[i] + 16'h0001;
            done_d[i] = 1'b1;
            mode_d[i] = DPC_IDLE;
          end
          DPC_CONT:
          begin
            pos_d[i] = motor_pos_i;
            cnt_d[i] = cnt_d[i] + 16'h0001;
            done_d[i] = 1'b1;
          end
          default:
          begin
            pos_d[i] = pos_d[i];
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < 2; i++)
      begin
        mode_q[i] <= DPC_IDLE;
        pos_q[i] <= DPC_POS_RST;
        cnt_q[i] <= DPC_CNT_RST;
      end
      edge_q <= {2{DPC_EDGE_RST}};
      done_q <= {2{DPC_DONE_RST}};
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        mode_q[i] <= mode_d[i];
        pos_q[i] <= pos_d[i];
        cnt_q[i] <= cnt_d[i];
      end
      edge_q <= edge_d;
      done_q <= done_d;
    end
  end

  // Parameter reads and write refusals
  always_comb
  begin
    logic wr_ok;
    logic rd_map;
    wr_ok = 1'b1;
    rd_map = 1'b1;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    err_d = 1'b0;

    if (param_rd_i)
    begin
      rvalid_d = 1'b1;
      case (param_addr_i)
        DPC_ADDR_STATUS: rdata_d = {30'h0, done_q[DPC_STATUS_B_BIT], done_q[DPC_STATUS_A_BIT]};
        DPC_ADDR_A_EDGE: rdata_d = {31'h0, edge_q[0]};
        DPC_ADDR_B_EDGE: rdata_d = {31'h0, edge_q[1]};
        DPC_ADDR_A_RUN: rdata_d = {16'h0, mode_code(mode_q[0])};
        DPC_ADDR_B_RUN: rdata_d = {16'h0, mode_code(mode_q[1])};
        DPC_ADDR_A_POS: rdata_d = pos_q[0];
        DPC_ADDR_B_POS: rdata_d = pos_q[1];
        DPC_ADDR_A_CNT: rdata_d = {16'h0, cnt_q[0]};
        DPC_ADDR_B_CNT: rdata_d = {16'h0, cnt_q[1]};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rd_map = 1'b0;
        end
      endcase
    end

    // Refused: read-only or unmapped address, value out of range, arming off fieldbus
    if (param_wr_i)
    begin
      if (run_wsel != 2'h0)
      begin
        if (param_wdata_i > {16'h0, DPC_RUN_CONT})
        begin
          wr_ok = 1'b0;
        end
        else if ((param_wdata_i[15:0] != DPC_RUN_ABORT) && !fieldbus_ctrl_i)
        begin
          wr_ok = 1'b0;
        end
      end
      else if (edge_wsel != 2'h0)
      begin
        wr_ok = (param_wdata_i <= {16'h0, DPC_EDGE_RISE});
      end
      else
      begin
        wr_ok = 1'b0;
      end
    end

    err_d = (param_wr_i & ~wr_ok) | (param_rd_i & ~rd_map);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      err_q <= err_d;
    end
  end

  assign param_rdata_o = rdata_q;
  assign param_rvalid_o = rvalid_q;
  assign param_err_o = err_q;
  assign capture_done_flags_o = done_q;

endmodule // dpc_capture_top

`default_nettype wire

// File: pkg/dpc_pkg.sv
/*
  Constants and types shared by the dual position capture block.
  Assumes a 16-bit fieldbus parameter address space and one 25 MHz clock.

*/
`default_nettype none

package dpc_pkg;

  // Parameter addresses
  localparam logic [15:0] DPC_ADDR_STATUS = 16'h0A02;
  localparam logic [15:0] DPC_ADDR_A_EDGE = 16'h0A04;
  localparam logic [15:0] DPC_ADDR_B_EDGE = 16'h0A06;
  localparam logic [15:0] DPC_ADDR_A_RUN = 16'h0A08;
  localparam logic [15:0] DPC_ADDR_B_RUN = 16'h0A0A;
  localparam logic [15:0] DPC_ADDR_A_POS = 16'h0A0C;
  localparam logic [15:0] DPC_ADDR_B_POS = 16'h0A0E;
  localparam logic [15:0] DPC_ADDR_A_CNT = 16'h0A10;
  localparam logic [15:0] DPC_ADDR_B_CNT = 16'h0A12;

  // Run control values
  localparam logic [15:0] DPC_RUN_ABORT = 16'h0000;
  localparam logic [15:0] DPC_RUN_SINGLE = 16'h0001;
  localparam logic [15:0] DPC_RUN_CONT = 16'h0002;

  // Edge select values
  localparam logic [15:0] DPC_EDGE_FALL = 16'h0000;
  localparam logic [15:0] DPC_EDGE_RISE = 16'h0001;

  // Status word bit positions
  localparam int DPC_STATUS_A_BIT = 0;
  localparam int DPC_STATUS_B_BIT = 1;

  // Reset values
  localparam logic DPC_EDGE_RST = 1'b0;
  localparam logic [15:0] DPC_CNT_RST = 16'h0000;
  localparam logic [31:0] DPC_POS_RST = 32'h0000_0000;
  localparam logic DPC_DONE_RST = 1'b0;
  localparam logic DPC_PIN_RST = 1'b0;

  typedef enum logic [1:0] {
    DPC_IDLE,
    DPC_SINGLE,
    DPC_CONT
  } dpc_mode_t;

endpackage

`default_nettype wire

// File: rtl/dpc_edge_sync.sv
/*
  Two-flop synchroniser and edge detector for one capture input.
  Assumes the pin is asynchronous to ref_clk_i and held long enough to be seen.
*/
`timescale 1ns/100ps
`default_nettype none

module dpc_edge_sync
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Pin and edges
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic last_q;
  logic last_d;

  always_comb
  begin
    meta_d = pin_i;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // Only sync_q reads meta_q; edges come from the two settled stages
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_q <= DPC_PIN_RST;
      sync_q <= DPC_PIN_RST;
      last_q <= DPC_PIN_RST;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // One transition gives exactly one single-cycle edge
  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;

endmodule // dpc_edge_sync

`default_nettype wire

// File: test/dpc_capture_sva.sv
/*
  Port assertions for the dual position capture block.
  Assumes it is bound to dpc_capture_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module dpc_capture_sva
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Pins and drive state
  input wire logic positive_limit_or_trigger_a_pin_i,
  input wire logic fieldbus_ctrl_i,
  // Parameter port
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [31:0] param_wdata_i,
  input wire logic [31:0] param_rdata_o,
  input wire logic param_rvalid_o,
  input wire logic param_err_o,
  input wire logic [1:0] capture_done_flags_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  wire logic wr_a_run = param_wr_i && param_addr_i == DPC_ADDR_A_RUN;
  wire logic wr_b_run = param_wr_i && param_addr_i == DPC_ADDR_B_RUN;

  a_read_answer: assert property (param_rd_i && param_addr_i == DPC_ADDR_A_EDGE |=> param_rvalid_o)
    else $error("read not answered");
  a_no_stray_valid: assert property (param_rvalid_o |-> $past(param_rd_i))
    else $error("read valid without read");
  a_rdata_hold: assert property (!param_rd_i |=> $stable(param_rdata_o))
    else $error("read data moved without read");
  a_run_range: assert property (wr_a_run && param_wdata_i > 32'h2 |=> param_err_o)
    else $error("run value above 2 accepted");
  a_arm_gate: assert property (
    wr_a_run && param_wdata_i inside {32'h1, 32'h2} && !fieldbus_ctrl_i |=> param_err_o)
    else $error("arming outside fieldbus control accepted");
  a_edge_range: assert property (
    param_wr_i && param_addr_i == DPC_ADDR_A_EDGE && param_wdata_i > 32'h1 |=> param_err_o)
    else $error("edge value above 1 accepted");
  a_pos_ro: assert property (param_wr_i && param_addr_i == DPC_ADDR_A_POS |=> param_err_o)
    else $error("position write accepted");
  a_status_read: assert property (
    param_rd_i && param_addr_i == DPC_ADDR_STATUS |=> param_rdata_o == {30'h0, $past(capture_done_flags_o)})
    else $error("status word differs from flags");
  a_flag_cause: assert property (
    $rose(capture_done_flags_o[0])
    |-> $past(positive_limit_or_trigger_a_pin_i, 2) != $past(positive_limit_or_trigger_a_pin_i, 5))
    else $error("unit A flag set without pin edge");
  a_flag_clear_a: assert property ($fell(capture_done_flags_o[0]) |-> $past(wr_a_run))
    else $error("unit A flag cleared without arming");
  a_flag_clear_b: assert property ($fell(capture_done_flags_o[1]) |-> $past(wr_b_run))
    else $error("unit B flag cleared without arming");
endmodule // dpc_capture_sva

bind dpc_capture_top dpc_capture_sva sva_u (
  .ref_clk_i,
  .nrst_i,
  .positive_limit_or_trigger_a_pin_i,
  .fieldbus_ctrl_i,
  .param_wr_i,
  .param_rd_i,
  .param_addr_i,
  .param_wdata_i,
  .param_rdata_o,
  .param_rvalid_o,
  .param_err_o,
  .capture_done_flags_o
);

`default_nettype wire

// File: test/dpc_trig_src.sv
/*
  Mark sensor model: one trigger line idling low.
  Assumes the bench calls pulse() after a clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module dpc_trig_src (
  // Clock
  input wire logic ref_clk_i,
  // Sensor line
  output logic pin_o
);
  initial pin_o = 1'b0;

  // Six cycles each way, well past the two the synchroniser needs
  task automatic pulse();
    repeat (2) @(posedge ref_clk_i);
    #2 pin_o = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #2 pin_o = 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule // dpc_trig_src

`default_nettype wire

// File: test/dpc_capture_tb_top.sv
/*
  Self-checking bench for the dual position capture block.
  Assumes the package constants give the parameter addresses.
*/
`timescale 1ns/100ps
`default_nettype none

module dpc_capture_tb_top
  import dpc_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pin_a;
  logic pin_b;
  logic [31:0] motor_pos_i = 32'h0;
  logic ref_update_i = 1'b0;
  logic [31:0] ref_delta_i = 32'h0;
  logic fieldbus_ctrl_i = 1'b1;
  logic param_wr_i = 1'b0;
  logic param_rd_i = 1'b0;
  logic [15:0] param_addr_i = 16'h0;
  logic [31:0] param_wdata_i = 32'h0;
  logic [31:0] param_rdata_o;
  logic param_rvalid_o;
  logic param_err_o;
  logic [1:0] capture_done_flags_o;
  logic [31:0] seed = 32'h878311B2;
  logic [31:0] expa;
  logic [31:0] expb;
  int fail_count = 0;
  int check_count = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  dpc_trig_src trig_a (.ref_clk_i(ref_clk_i), .pin_o(pin_a));
  dpc_trig_src trig_b (.ref_clk_i(ref_clk_i), .pin_o(pin_b));

  dpc_capture_top dut_u (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .positive_limit_or_trigger_a_pin_i(pin_a),
    .negative_limit_or_trigger_b_pin_i(pin_b),
    .motor_pos_i(motor_pos_i),
    .ref_update_i(ref_update_i),
    .ref_delta_i(ref_delta_i),
    .fieldbus_ctrl_i(fieldbus_ctrl_i),
    .param_wr_i(param_wr_i),
    .param_rd_i(param_rd_i),
    .param_addr_i(param_addr_i),
    .param_wdata_i(param_wdata_i),
    .param_rdata_o(param_rdata_o),
    .param_rvalid_o(param_rvalid_o),
    .param_err_o(param_err_o),
    .capture_done_flags_o(capture_done_flags_o)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // One transfer; the answer is looked at in the cycle it stands
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic err);
    @(posedge ref_clk_i);
    #2 param_wr_i = w;
    param_rd_i = !w;
    param_addr_i = a;
    param_wdata_i = d;
    @(posedge ref_clk_i);
    #2 param_wr_i = 1'b0;
    param_rd_i = 1'b0;
    chk($sformatf("err %h", a), {31'h0, err}, {31'h0, param_err_o});
    chk($sformatf("rvalid %h", a), {31'h0, !w}, {31'h0, param_rvalid_o});
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic err);
    bus(1'b0, a, 32'h0, err);
    chk($sformatf("rdata %h", a), e, param_rdata_o);
  endtask

  task automatic new_pos();
    seed = lfsr(seed);
    motor_pos_i = seed;
  endtask

  initial
  begin
    repeat (6000) @(posedge ref_clk_i);
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    #2 nrst_i = 1'b1;
    rd_chk(DPC_ADDR_A_EDGE, 32'h0, 1'b0);
    rd_chk(DPC_ADDR_A_RUN, 32'h0, 1'b0);
    rd_chk(DPC_ADDR_A_CNT, 32'h0, 1'b0);
    rd_chk(16'h0A40, 32'h0, 1'b1);
    bus(1'b1, DPC_ADDR_A_POS, 32'h5, 1'b1);
    bus(1'b1, DPC_ADDR_A_RUN, 32'h3, 1'b1);
    bus(1'b1, DPC_ADDR_A_EDGE, 32'h2, 1'b1);
    // Upper half set: refused, and the unit must stay idle
    bus(1'b1, DPC_ADDR_B_RUN, 32'h0001_0001, 1'b1);
    rd_chk(DPC_ADDR_B_RUN, 32'h0, 1'b0);
    fieldbus_ctrl_i = 1'b0;
    bus(1'b1, DPC_ADDR_A_RUN, 32'h1, 1'b1);
    rd_chk(DPC_ADDR_A_RUN, 32'h0, 1'b0);
    fieldbus_ctrl_i = 1'b1;
    bus(1'b1, DPC_ADDR_A_EDGE, 32'h1, 1'b0);
    bus(1'b1, DPC_ADDR_A_RUN, 32'h1, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      new_pos();
      if (k == 0)
        expa = motor_pos_i;
      trig_a.pulse();
    end
    rd_chk(DPC_ADDR_A_POS, expa, 1'b0);
    rd_chk(DPC_ADDR_A_CNT, 32'h1, 1'b0);
    rd_chk(DPC_ADDR_A_RUN, 32'h0, 1'b0);
    rd_chk(DPC_ADDR_STATUS, 32'h1, 1'b0);
    bus(1'b1, DPC_ADDR_B_RUN, 32'h2, 1'b0);
    repeat (3)
    begin
      new_pos();
      expb = motor_pos_i;
      trig_b.pulse();
    end
    rd_chk(DPC_ADDR_B_POS, expb, 1'b0);
    rd_chk(DPC_ADDR_B_CNT, 32'h3, 1'b0);
    rd_chk(DPC_ADDR_A_CNT, 32'h1, 1'b0);
    rd_chk(DPC_ADDR_STATUS, 32'h3, 1'b0);
    bus(1'b1, DPC_ADDR_B_RUN, 32'h0, 1'b0);
    trig_b.pulse();
    rd_chk(DPC_ADDR_B_CNT, 32'h3, 1'b0);
    seed = lfsr(seed);
    @(posedge ref_clk_i);
    #2 ref_update_i = 1'b1;
    ref_delta_i = seed;
    @(posedge ref_clk_i);
    #2 ref_update_i = 1'b0;
    rd_chk(DPC_ADDR_A_POS, expa + seed, 1'b0);
    rd_chk(DPC_ADDR_B_POS, expb + seed, 1'b0);
    bus(1'b1, DPC_ADDR_A_RUN, 32'h2, 1'b0);
    rd_chk(DPC_ADDR_A_CNT, 32'h0, 1'b0);
    rd_chk(DPC_ADDR_STATUS, 32'h2, 1'b0);
    // Re-arm B single: its flag and count clear, then one falling edge completes it
    bus(1'b1, DPC_ADDR_B_RUN, 32'h1, 1'b0);
    rd_chk(DPC_ADDR_B_CNT, 32'h0, 1'b0);
    rd_chk(DPC_ADDR_STATUS, 32'h0, 1'b0);
    rd_chk(DPC_ADDR_B_RUN, 32'h1, 1'b0);
    new_pos();
    expb = motor_pos_i;
    trig_b.pulse();
    rd_chk(DPC_ADDR_B_POS, expb, 1'b0);
    rd_chk(DPC_ADDR_B_RUN, 32'h0, 1'b0);
    rd_chk(DPC_ADDR_STATUS, 32'h2, 1'b0);
    conclude();
  end
endmodule // dpc_capture_tb_top

`default_nettype wire
